// ### rtl/charge_setpoint_defines.svh
// Offsets, field positions, reset values and scaling constants of the
// charge set-point register bank.
// Assumes it is included by bare name from the package and the bank files.
//
// How it works
// R1: Termination bit 7 picks range: 0 is 500 uA steps, 1 is 1 mA steps.
// R2: Termination bits 6..2 are a five-bit current code weighted per range.
// R3: Termination bit 1 enables end-of-charge cutoff and resets to one.
// R4: Termination register resets to 0x0E: low range, code 00011, cutoff on.
// R5: Voltage bits 7..1 form a code; regulation is 3.6 V plus code times 10 mV.
// R6: A written voltage code above 105 is stored as 105, meaning 4.65 V.
// R7: Voltage register default is the programmed value, printed as 0x78.
// R8: Output bit 7 enables the buck; zero disables and pulls output low.
// R9: Range select 00 low table, 01 from 1.3 V, 10 not valid, 11 from 1.8 V.
// R10: With select 01 or 11 the level is base plus code times 100 mV.
// R11: With select 00, codes give 1.1, 1.2, 1.25 V then about 83 mV steps.
// R12: Output register resets to 0xAA, leaving the buck output enabled; the code pulls it low in reset until the first edge after release.
// R13: Bit 0 of termination and voltage registers is plain storage, reset 0.
`ifndef CHARGE_SETPOINT_DEFINES_SVH
`define CHARGE_SETPOINT_DEFINES_SVH

`define TERM_ADDR 8'h04
`define VREG_ADDR 8'h05
`define BUCK_ADDR 8'h06

`define TERM_RESET 8'h0E
`define VREG_RESET 8'h78
`define BUCK_RESET 8'hAA

`define TERM_RANGE_BIT 7
`define TERM_CODE_MSB 6
`define TERM_CODE_LSB 2
`define TERM_EN_BIT 1
`define SPARE_BIT 0
`define VREG_CODE_MSB 7
`define VREG_CODE_LSB 1
`define BUCK_EN_BIT 7
`define BUCK_SEL_MSB 6
`define BUCK_SEL_LSB 5
`define BUCK_CODE_MSB 3
`define BUCK_CODE_LSB 0

`define VREG_CODE_MAX 7'h69
`define TERM_LOW_STEP_UA 16'h01F4
`define TERM_HIGH_STEP_UA 16'h03E8
`define FLOAT_BASE_MV 16'h0E10
`define FLOAT_STEP_MV 16'h000A
`define LEVEL_STEP_MV 16'h0064
`define LEVEL_01_BASE_MV 16'h0514
`define LEVEL_11_BASE_MV 16'h0708
`define LEVEL_00_C0_MV 16'h044C
`define LEVEL_00_C1_MV 16'h04B0
`define LEVEL_00_BASE_MV 16'h04E2
`define LEVEL_10_BASE_MV 16'h05DC
`define LEVEL_FINE_STEP 16'h00FA
`define LEVEL_FINE_DIV 16'h0003
`define LEVEL_00_FIRST 4'h2

`endif

// ### rtl/charge_setpoint_pkg.sv
// Types shared by the charge set-point register bank and its users.
// Assumes the defines header is on the include path.
`include "charge_setpoint_defines.svh"

package charge_setpoint_pkg;

  typedef enum logic [1:0] {
    RANGE_LOW_TABLE = 2'b00,
    RANGE_FROM_1V3 = 2'b01,
    RANGE_NOT_VALID = 2'b10,
    RANGE_FROM_1V8 = 2'b11
  } output_range_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic termination_range_select;
    logic [4:0] termination_current_code;
    logic end_of_charge_cutoff_on;
    logic [15:0] termination_current_ua;
    logic [6:0] battery_regulation_code;
    logic [15:0] battery_float_voltage_mv;
    logic buck_output_on;
    logic [1:0] output_range_select;
    logic [3:0] output_level_code;
    logic [15:0] output_level_mv;
    logic output_range_valid;
  } setpoints_s;

endpackage

// ### rtl/setpoint_reg.sv
// One read-write set-point register with a constant reset value.
// Assumes write strobe and data come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none

module setpoint_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write side
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wdata,
  // Stored value
  output logic [WIDTH-1:0] q
);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= RESET_VALUE;
    end else if (wr_en) begin
      q <= wdata;
    end
  end

endmodule

`default_nettype wire

// ### rtl/charge_setpoint_registers.sv
// Termination, battery regulation and buck output set-point registers,
// with decoded set-points for the analog side.
// Assumes the serial interface delivers single-cycle requests on SYS_CLK.
`timescale 1ns/10ps
`default_nettype none
`include "charge_setpoint_defines.svh"

module charge_setpoint_registers #(
  // Programmed default of the regulation register.
  parameter logic [7:0] VREG_DEFAULT = `VREG_RESET
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // Register access from the serial interface
  input wire charge_setpoint_pkg::reg_req_s REG_REQ,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  // Decoded set-points
  output charge_setpoint_pkg::setpoints_s SETPOINTS,
  output logic BUCK_OUTPUT_PIN_PULL_LOW
);

  logic [7:0] term_q;
  logic [7:0] vreg_q;
  logic [7:0] buck_q;
  logic term_wr;
  logic vreg_wr;
  logic buck_wr;
  logic [6:0] written_code;
  logic [6:0] next_vreg_code;
  logic [7:0] next_rdata;
  charge_setpoint_pkg::setpoints_s next_setpoints;

  assign term_wr = REG_REQ.wr && (REG_REQ.addr == `TERM_ADDR);
  assign vreg_wr = REG_REQ.wr && (REG_REQ.addr == `VREG_ADDR);
  assign buck_wr = REG_REQ.wr && (REG_REQ.addr == `BUCK_ADDR);

  // R4: termination reset value
  setpoint_reg #(
    .WIDTH(8),
    .RESET_VALUE(`TERM_RESET)
  ) u_term (
    .clk(SYS_CLK),
    .rst(RST),
    .wr_en(term_wr),
    .wdata(REG_REQ.wdata),
    .q(term_q)
  );

  // R6: saturate regulation code
  assign written_code = REG_REQ.wdata[`VREG_CODE_MSB:`VREG_CODE_LSB];
  always_comb begin
    if (written_code > `VREG_CODE_MAX) begin
      next_vreg_code = `VREG_CODE_MAX;
    end else begin
      next_vreg_code = written_code;
    end
  end

  // R7: programmed default
  setpoint_reg #(
    .WIDTH(8),
    .RESET_VALUE(VREG_DEFAULT)
  ) u_vreg (
    .clk(SYS_CLK),
    .rst(RST),
    .wr_en(vreg_wr),
    // R13: spare bit kept
    .wdata({next_vreg_code, REG_REQ.wdata[`SPARE_BIT]}),
    .q(vreg_q)
  );

  // R12: output control reset value
  setpoint_reg #(
    .WIDTH(8),
    .RESET_VALUE(`BUCK_RESET)
  ) u_buck (
    .clk(SYS_CLK),
    .rst(RST),
    .wr_en(buck_wr),
    .wdata(REG_REQ.wdata),
    .q(buck_q)
  );

  // Read decode; unmapped addresses read as zero and ignore writes.
  always_comb begin
    if (REG_REQ.addr == `TERM_ADDR) begin
      next_rdata = term_q;
    end else if (REG_REQ.addr == `VREG_ADDR) begin
      next_rdata = vreg_q;
    end else if (REG_REQ.addr == `BUCK_ADDR) begin
      next_rdata = buck_q;
    end else begin
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_REQ.rd;
      if (REG_REQ.rd) begin
        REG_RDATA <= next_rdata;
      end
    end
  end

  // R2: termination current weights
  function automatic logic [15:0] term_ua(input logic range,
                                          input logic [4:0] code);
    logic [15:0] wide;
    wide = {11'h000, code};
    // R1: range step select
    if (range) begin
      term_ua = 16'(wide * `TERM_HIGH_STEP_UA);
    end else begin
      term_ua = 16'(wide * `TERM_LOW_STEP_UA);
    end
  endfunction

  // R5: regulation voltage equation
  function automatic logic [15:0] float_mv(input logic [6:0] code);
    float_mv = 16'(`FLOAT_BASE_MV + {9'h000, code} * `FLOAT_STEP_MV);
  endfunction

  // The thirds of 250 mV are rounded to the nearest millivolt.
  function automatic logic [15:0] level_mv(input logic [1:0] sel,
                                           input logic [3:0] code);
    logic [15:0] wide;
    logic [15:0] fine;
    wide = {12'h000, code};
    fine = 16'h0000;
    level_mv = 16'h0000;
    case (charge_setpoint_pkg::output_range_e'(sel))
      // R11: low table range
      charge_setpoint_pkg::RANGE_LOW_TABLE: begin
        if (code == 4'h0) begin
          level_mv = `LEVEL_00_C0_MV;
        end else if (code == 4'h1) begin
          level_mv = `LEVEL_00_C1_MV;
        end else begin
          fine = 16'((16'(wide - {12'h000, `LEVEL_00_FIRST}) *
                      `LEVEL_FINE_STEP + 16'h0001) / `LEVEL_FINE_DIV);
          level_mv = 16'(`LEVEL_00_BASE_MV + fine);
        end
      end
      // R10: 100 mV steps
      charge_setpoint_pkg::RANGE_FROM_1V3: begin
        level_mv = 16'(`LEVEL_01_BASE_MV + wide * `LEVEL_STEP_MV);
      end
      charge_setpoint_pkg::RANGE_FROM_1V8: begin
        level_mv = 16'(`LEVEL_11_BASE_MV + wide * `LEVEL_STEP_MV);
      end
      default: begin
        fine = 16'((wide * `LEVEL_FINE_STEP + 16'h0001) / `LEVEL_FINE_DIV);
        level_mv = 16'(`LEVEL_10_BASE_MV + fine);
      end
    endcase
  endfunction

  always_comb begin
    next_setpoints.termination_range_select = term_q[`TERM_RANGE_BIT];
    next_setpoints.termination_current_code =
      term_q[`TERM_CODE_MSB:`TERM_CODE_LSB];
    // R3: cutoff enable bit
    next_setpoints.end_of_charge_cutoff_on = term_q[`TERM_EN_BIT];
    next_setpoints.termination_current_ua =
      term_ua(term_q[`TERM_RANGE_BIT], term_q[`TERM_CODE_MSB:`TERM_CODE_LSB]);
    next_setpoints.battery_regulation_code =
      vreg_q[`VREG_CODE_MSB:`VREG_CODE_LSB];
    next_setpoints.battery_float_voltage_mv =
      float_mv(vreg_q[`VREG_CODE_MSB:`VREG_CODE_LSB]);
    next_setpoints.buck_output_on = buck_q[`BUCK_EN_BIT];
    next_setpoints.output_range_select = buck_q[`BUCK_SEL_MSB:`BUCK_SEL_LSB];
    next_setpoints.output_level_code = buck_q[`BUCK_CODE_MSB:`BUCK_CODE_LSB];
    next_setpoints.output_level_mv =
      level_mv(buck_q[`BUCK_SEL_MSB:`BUCK_SEL_LSB],
               buck_q[`BUCK_CODE_MSB:`BUCK_CODE_LSB]);
    // R9: select 10 is not valid
    next_setpoints.output_range_valid =
      (buck_q[`BUCK_SEL_MSB:`BUCK_SEL_LSB] !=
       charge_setpoint_pkg::RANGE_NOT_VALID);
  end

  // Decoded values are registered so the analog side sees clean levels;
  // this costs one cycle after the register changes.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      SETPOINTS <= '0;
      BUCK_OUTPUT_PIN_PULL_LOW <= 1'b1;
    end else begin
      SETPOINTS <= next_setpoints;
      // R8: disabled output pulled low
      BUCK_OUTPUT_PIN_PULL_LOW <= ~buck_q[`BUCK_EN_BIT];
    end
  end

  // Spare bits 0 of the first two registers only read back.
  // R13: spare bit storage
  chk_spare_store: assert property ( // R13
    @(posedge SYS_CLK) disable iff (RST)
    (term_wr || vreg_wr) |=>
      (($past(term_wr) ? term_q[`SPARE_BIT] : vreg_q[`SPARE_BIT]) ==
       $past(REG_REQ.wdata[`SPARE_BIT])))
    else $error("spare bit 0 not stored");

  chk_term_reset: assert property ( // R4
    @(posedge SYS_CLK) $fell(RST) |-> (term_q == `TERM_RESET))
    else $error("termination register reset value wrong");

  chk_buck_reset: assert property ( // R12
    @(posedge SYS_CLK) $fell(RST) |-> (buck_q == `BUCK_RESET))
    else $error("output control register reset value wrong");

  chk_vreg_reset: assert property ( // R7
    @(posedge SYS_CLK) $fell(RST) |-> (vreg_q == VREG_DEFAULT))
    else $error("regulation register default wrong");

  chk_vreg_saturate: assert property ( // R6
    @(posedge SYS_CLK) disable iff (RST)
    (vreg_wr && (written_code > `VREG_CODE_MAX)) |=>
      (vreg_q[`VREG_CODE_MSB:`VREG_CODE_LSB] == `VREG_CODE_MAX))
    else $error("regulation code not saturated at 105");

  chk_vreg_pass: assert property ( // R5
    @(posedge SYS_CLK) disable iff (RST)
    (vreg_wr && (written_code <= `VREG_CODE_MAX)) |=> ##1
      (SETPOINTS.battery_float_voltage_mv ==
       16'(`FLOAT_BASE_MV + {9'h000, $past(written_code, 2)} *
           `FLOAT_STEP_MV)))
    else $error("regulation voltage does not follow written code");

  chk_cutoff_follow: assert property ( // R3
    @(posedge SYS_CLK) disable iff (RST)
    term_wr |=> ##1
      (SETPOINTS.end_of_charge_cutoff_on ==
       $past(REG_REQ.wdata[`TERM_EN_BIT], 2)))
    else $error("cutoff enable does not follow write");

  chk_term_range: assert property ( // R1
    @(posedge SYS_CLK) disable iff (RST)
    (SETPOINTS.termination_range_select &&
     SETPOINTS.termination_current_code == 5'h01) |->
      (SETPOINTS.termination_current_ua == `TERM_HIGH_STEP_UA))
    else $error("high range step is not 1 mA");

  chk_term_weight: assert property ( // R2
    @(posedge SYS_CLK) disable iff (RST)
    (!SETPOINTS.termination_range_select &&
     SETPOINTS.termination_current_code == 5'h10) |->
      (SETPOINTS.termination_current_ua == 16'h1F40))
    else $error("low range top bit is not 8 mA");

  chk_pull_low: assert property ( // R8
    @(posedge SYS_CLK) disable iff (RST)
    BUCK_OUTPUT_PIN_PULL_LOW == !SETPOINTS.buck_output_on)
    else $error("pull-low does not mirror buck disable");

  // Set-points are all zero in reset, so the first edge after release is
  // skipped; the decoded values only arrive one edge later.
  chk_range_valid: assert property ( // R9
    @(posedge SYS_CLK) disable iff (RST)
    !$past(RST) |->
      (SETPOINTS.output_range_valid ==
       (SETPOINTS.output_range_select != 2'b10)))
    else $error("range valid flag wrong");

  chk_level_step: assert property ( // R10
    @(posedge SYS_CLK) disable iff (RST)
    (SETPOINTS.output_range_select == 2'b11) |->
      (SETPOINTS.output_level_mv == 16'(`LEVEL_11_BASE_MV +
        {12'h000, SETPOINTS.output_level_code} * `LEVEL_STEP_MV)))
    else $error("level in 1.8 V range wrong");

  chk_level_table: assert property ( // R11
    @(posedge SYS_CLK) disable iff (RST)
    (SETPOINTS.output_range_select == 2'b00 &&
     SETPOINTS.output_level_code == 4'hF) |->
      (SETPOINTS.output_level_mv == 16'h091D))
    else $error("low table top code is not 2.333 V");

  chk_read_answer: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    REG_REQ.rd |=> REG_RVALID && (REG_RDATA == $past(next_rdata)))
    else $error("read answer wrong or late");

  cov_saturating_write: cover property (
    @(posedge SYS_CLK) disable iff (RST)
    vreg_wr && (written_code > `VREG_CODE_MAX));

  cov_buck_off: cover property (
    @(posedge SYS_CLK) disable iff (RST)
    $rose(BUCK_OUTPUT_PIN_PULL_LOW));

  cov_high_range: cover property (
    @(posedge SYS_CLK) disable iff (RST)
    $rose(SETPOINTS.termination_range_select));

  cov_unmapped_read: cover property (
    @(posedge SYS_CLK) disable iff (RST)
    REG_REQ.rd && (next_rdata == 8'h00) && (REG_REQ.addr > `BUCK_ADDR));

endmodule

`default_nettype wire

// ### bench/setpoint_host_model.sv
// Host model that configures the set-point bank over its request port.
// Assumes same-clock single-cycle requests, answered one cycle later.
`timescale 1ns/10ps
`default_nettype none

module setpoint_host_model (
  // Clock
  input wire logic clk,
  // Request and answer
  output charge_setpoint_pkg::reg_req_s req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial req = '0;

  // A gap cycle follows each request, so strobes never merge.
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
  endtask

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
                          output logic ok);
    @(posedge clk);
    req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    ok = (rvalid === 1'b1);
    data = rdata;
  endtask
endmodule

`default_nettype wire

// ### bench/charge_setpoint_registers_tb_top.sv
// Self-checking bench for the charge set-point register bank.
// Assumes the host model drives the request port on SYS_CLK.
`timescale 1ns/10ps
`default_nettype none
`include "charge_setpoint_defines.svh"

module charge_setpoint_registers_tb_top;
  logic clk;
  logic rst;
  charge_setpoint_pkg::reg_req_s req;
  logic [7:0] rdata;
  logic rvalid;
  charge_setpoint_pkg::setpoints_s sp;
  logic pull_low;
  int miscompares;
  int compares;
  localparam logic [7:0] TERM_D [3] = '{8'h7C, 8'hFF, 8'h84};
  localparam logic [15:0] TERM_UA [3] = '{16'h3C8C, 16'h7918, 16'h03E8};
  localparam logic [7:0] VREG_D [4] = '{8'h01, 8'hD2, 8'hD4, 8'hFF};
  localparam logic [7:0] VREG_Q [4] = '{8'h01, 8'hD2, 8'hD2, 8'hD3};
  localparam logic [15:0] VREG_MV [4] = '{16'h0E10, 16'h122A, 16'h122A,
                                          16'h122A};
  localparam logic [7:0] BUCK_D [8] = '{8'h80, 8'h81, 8'h82, 8'h8F,
                                        8'hAF, 8'hEF, 8'hC0, 8'h60};
  localparam logic [15:0] BUCK_MV [8] = '{16'h044C, 16'h04B0, 16'h04E2,
    16'h091D, 16'h0AF0, 16'h0CE4, 16'h05DC, 16'h0708};
  localparam logic [7:0] BUCK_OK = 8'hBF;

  charge_setpoint_registers uut (
    .SYS_CLK(clk),
    .RST(rst),
    .REG_REQ(req),
    .REG_RDATA(rdata),
    .REG_RVALID(rvalid),
    .SETPOINTS(sp),
    .BUCK_OUTPUT_PIN_PULL_LOW(pull_low)
  );

  setpoint_host_model host (
    .clk(clk),
    .req(req),
    .rdata(rdata),
    .rvalid(rvalid)
  );

  initial clk = 1'b0;
  always #4 clk = ~clk;

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.read_reg(addr, d, ok);
    check(16'(ok), 16'h0001, "read valid");
    check(16'(d), 16'(exp), "read data");
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    host.write_reg(addr, data);
    repeat (2) @(negedge clk);
  endtask

  // SETPOINTS settle one edge after release, hence the two negedges.
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic reg_rst_check();
    rd(`TERM_ADDR, `TERM_RESET);
    rd(`VREG_ADDR, `VREG_RESET);
    rd(`BUCK_ADDR, `BUCK_RESET);
  endtask

  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    $display("ERROR %0t watchdog expired", $time);
    results();
  end

  initial begin
    miscompares = 0;
    compares = 0;
    rst = 1'b1;
    do_reset();
    check(16'(sp.end_of_charge_cutoff_on), 16'h0001, "cutoff rst");
    check(sp.termination_current_ua, 16'h05DC, "term rst");
    check(sp.battery_float_voltage_mv, 16'h1068, "vreg rst");
    check(16'(sp.buck_output_on), 16'h0001, "buck rst");
    check(16'(pull_low), 16'h0000, "pull rst");
    check(sp.output_level_mv, 16'h08FC, "level rst");
    reg_rst_check();
    for (int i = 0; i < 3; i++) begin
      wr(`TERM_ADDR, TERM_D[i]);
      check(16'(sp.termination_range_select), 16'(TERM_D[i][7]), "rng");
      check(16'(sp.termination_current_code), 16'(TERM_D[i][6:2]), "tc");
      check(sp.termination_current_ua, TERM_UA[i], "term ua");
      check(16'(sp.end_of_charge_cutoff_on), 16'(TERM_D[i][1]), "te");
      rd(`TERM_ADDR, TERM_D[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(`VREG_ADDR, VREG_D[i]);
      check(16'(sp.battery_regulation_code), 16'(VREG_Q[i][7:1]), "vc");
      check(sp.battery_float_voltage_mv, VREG_MV[i], "vreg mv");
      rd(`VREG_ADDR, VREG_Q[i]);
    end
    for (int i = 0; i < 8; i++) begin
      wr(`BUCK_ADDR, BUCK_D[i]);
      check(16'(sp.buck_output_on), 16'(BUCK_D[i][7]), "buck on");
      check(16'(pull_low), {15'h0000, ~BUCK_D[i][7]}, "pull low");
      check(16'(sp.output_range_select), 16'(BUCK_D[i][6:5]), "sel");
      check(16'(sp.output_level_code), 16'(BUCK_D[i][3:0]), "lvl");
      check(sp.output_level_mv, BUCK_MV[i], "level mv");
      check(16'(sp.output_range_valid), 16'(BUCK_OK[i]), "valid");
      rd(`BUCK_ADDR, BUCK_D[i]);
    end
    wr(8'h07, 8'h5A);
    rd(8'h07, 8'h00);
    rd(`BUCK_ADDR, BUCK_D[7]);
    do_reset();
    reg_rst_check();
    check(16'(pull_low), 16'h0000, "pull rst2");
    results();
  end
endmodule

`default_nettype wire
